// [verilog/swcq_engine.sv]
// Write command queue engine: staging, two submission rings, arbitration, completion ring.
//
// The placing of the registers and register access over Wishbone are this design's own decisions.
`timescale 1ns/1ps
module swcq_engine (
  // Clock and reset.
  input wire logic i_mclk,
  input wire logic i_rst_b,
  // Wishbone slave.
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [31:0] i_wb_dat,
  input wire logic [3:0] i_wb_sel,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  // Execution port towards the media back end.
  output logic o_exec_valid,
  output swcq_pkg::swcq_exec_s o_exec,
  input wire logic i_exec_done,
  input wire logic i_exec_committed,
  input wire logic [7:0] i_exec_status,
  // Completion pending level.
  output logic o_cq_pending
);
  typedef logic [31:0] swcq_word_t;

  function automatic logic [1:0] ring_dist(input logic [1:0] a, input logic [1:0] b);
    ring_dist = 2'(a - b);
  endfunction

  function automatic swcq_pkg::swcq_ptr2_e ptr2_use(input logic [63:0] p1,
                                                    input logic [15:0] block_count_minus_one);
    logic [29:0] bytes;
    logic [29:0] first;
    bytes = 30'({14'h0, block_count_minus_one} + 30'h1) * swcq_pkg::BLOCK_BYTES;
    first = swcq_pkg::PAGE_BYTES - {18'h0, p1[11:0]};
    if (bytes <= first) begin
      ptr2_use = swcq_pkg::PTR2_IGNORED;
    end else if (bytes <= 30'(first + swcq_pkg::PAGE_BYTES)) begin
      ptr2_use = swcq_pkg::PTR2_DATA;
    end else begin
      ptr2_use = swcq_pkg::PTR2_LIST;
    end
  endfunction

  function automatic swcq_pkg::swcq_exec_s decode(input swcq_word_t w [swcq_pkg::NWORDS],
                                                  input logic sq, input logic prot);
    swcq_pkg::swcq_exec_s e;
    e = '0;
    e.sq_id = sq;
    e.high_priority = !sq;
    e.cid = w[swcq_pkg::W_CMD0][31:16];
    e.metadata_pointer = {w[swcq_pkg::W_MD_LO + 4'h1], w[swcq_pkg::W_MD_LO]};
    e.first_data_pointer = {w[swcq_pkg::W_P1_LO + 4'h1], w[swcq_pkg::W_P1_LO]};
    e.second_data_pointer = {w[swcq_pkg::W_P2_LO + 4'h1], w[swcq_pkg::W_P2_LO]};
    e.ptr2_use = ptr2_use(e.first_data_pointer, w[swcq_pkg::W_CDW12][15:0]);
    e.start_block_address = {w[swcq_pkg::W_CDW10 + 4'h1], w[swcq_pkg::W_CDW10]};
    e.block_count = {1'b0, w[swcq_pkg::W_CDW12][15:0]} + 17'h1;
    if (w[swcq_pkg::W_CMD0][7:0] == swcq_pkg::OP_WRITE) begin
      e.limited_retry_flag = w[swcq_pkg::W_CDW12][31];
      e.force_media_flag = w[swcq_pkg::W_CDW12][30];
      e.protection_action_field = w[swcq_pkg::W_CDW12][29:26];
      e.dataset_hint_field = w[swcq_pkg::W_CDW13][7:0];
      e.incompressible = w[swcq_pkg::W_CDW13][7];
      if (prot) begin
        e.initial_reference_tag = w[swcq_pkg::W_CDW14];
        e.application_tag_mask = w[swcq_pkg::W_CDW15][31:16];
        e.application_tag_value = w[swcq_pkg::W_CDW15][15:0];
      end
    end
    decode = e;
  endfunction

  function automatic logic overlaps(input logic [63:0] s0, input logic [63:0] l0,
                                    input logic [63:0] s1, input logic [63:0] l1);
    overlaps = (s0 <= l1) && (s1 <= l0);
  endfunction

  // Register and ring state.
  swcq_word_t stage_q [swcq_pkg::NWORDS];
  swcq_word_t stage_d [swcq_pkg::NWORDS];
  swcq_word_t sq_q [2][4][swcq_pkg::NWORDS];
  swcq_word_t sq_d [2][4][swcq_pkg::NWORDS];
  logic [1:0] tail_q [2];
  logic [1:0] tail_d [2];
  logic [1:0] head_q [2];
  logic [1:0] head_d [2];
  swcq_pkg::swcq_cqe_s cq_q [4];
  swcq_pkg::swcq_cqe_s cq_d [4];
  logic [1:0] cq_tail_q, cq_tail_d, cq_head_q, cq_head_d;
  swcq_pkg::swcq_bad_s bad_q [swcq_pkg::BAD_N];
  swcq_pkg::swcq_bad_s bad_d [swcq_pkg::BAD_N];
  logic [63:0] query_q, query_d;
  logic prot_q, prot_d;
  logic ack_q, ack_d;
  logic [31:0] rdat_q, rdat_d;
  swcq_pkg::swcq_state_e state_q, state_d;
  swcq_pkg::swcq_exec_s cmd_q, cmd_d;
  logic [7:0] status_q, status_d;
  logic [1:0] fair_q, fair_d;

  logic req;
  logic wr;
  logic [1:0] cnt [2];
  logic full [2];
  logic cq_full;
  logic sel;
  logic query_bad;
  logic [63:0] last_blk;
  logic placed;
  swcq_word_t pick [swcq_pkg::NWORDS];

  always_comb begin
    req = i_wb_cyc && i_wb_stb && !ack_q;
    wr = req && i_wb_we;
    for (int q = 0; q < 2; q++) begin
      cnt[q] = ring_dist(tail_q[q], head_q[q]);
      full[q] = (cnt[q] == 2'h3);
    end
    cq_full = (ring_dist(cq_tail_q, cq_head_q) == 2'h3);
    // Queue 0 is the high priority ring; a burst limit keeps queue 1 from starving.
    sel = (cnt[1] != 2'h0) && ((cnt[0] == 2'h0) || (fair_q == swcq_pkg::FAIR_BURST));
    pick = sq_q[sel][head_q[sel]];
    query_bad = 1'b0;
    for (int b = 0; b < swcq_pkg::BAD_N; b++) begin
      if (bad_q[b].valid && overlaps(query_q, query_q, bad_q[b].first, bad_q[b].last)) begin
        query_bad = 1'b1;
      end
    end
    last_blk = cmd_q.start_block_address + {47'h0, cmd_q.block_count} - 64'h1;
  end

  // Bus side: staging, doorbells, configuration and read mux.
  always_comb begin
    stage_d = stage_q;
    sq_d = sq_q;
    tail_d = tail_q;
    cq_head_d = cq_head_q;
    query_d = query_q;
    prot_d = prot_q;
    ack_d = req;
    rdat_d = rdat_q;
    if (wr && (i_wb_adr <= swcq_pkg::A_STAGE_LAST) && (i_wb_adr[1:0] == 2'h0)) begin
      for (int k = 0; k < 4; k++) begin
        if (i_wb_sel[k]) begin
          stage_d[i_wb_adr[5:2]][k*8 +: 8] = i_wb_dat[k*8 +: 8];
        end
      end
    end
    if (wr) begin
      case (i_wb_adr)
        swcq_pkg::A_SLOT_WRITE: begin
          // A full ring refuses the copy; the slot index comes from the write data and is not checked against unfetched commands.
          if (!full[i_wb_dat[8]]) begin
            sq_d[i_wb_dat[8]][i_wb_dat[1:0]] = stage_q;
          end
        end
        swcq_pkg::A_SQ0_TAIL: tail_d[0] = i_wb_dat[1:0];
        swcq_pkg::A_SQ1_TAIL: tail_d[1] = i_wb_dat[1:0];
        swcq_pkg::A_CQ_HEAD: cq_head_d = i_wb_dat[1:0];
        swcq_pkg::A_CONFIG: prot_d = i_wb_dat[0];
        swcq_pkg::A_QUERY_LO: query_d[31:0] = i_wb_dat;
        swcq_pkg::A_QUERY_HI: query_d[63:32] = i_wb_dat;
        default: begin
        end
      endcase
    end
    if (req) begin
      rdat_d = 32'h0000_0000;
      if ((i_wb_adr <= swcq_pkg::A_STAGE_LAST) && (i_wb_adr[1:0] == 2'h0)) begin
        rdat_d = stage_q[i_wb_adr[5:2]];
      end else begin
        case (i_wb_adr)
          swcq_pkg::A_SQ0_TAIL: rdat_d = {30'h0, tail_q[0]};
          swcq_pkg::A_SQ1_TAIL: rdat_d = {30'h0, tail_q[1]};
          swcq_pkg::A_CQ_HEAD: rdat_d = {30'h0, cq_head_q};
          swcq_pkg::A_CQ_ENTRY: begin
            rdat_d = {cq_q[cq_head_q].cid, cq_q[cq_head_q].status, 2'h0,
                      cq_q[cq_head_q].sq_head, 3'h0, cq_q[cq_head_q].sq_id};
          end
          swcq_pkg::A_STATUS: begin
            rdat_d = {20'h0, full[1], full[0], cq_head_q, cq_tail_q, head_q[1], head_q[0],
                      (state_q != swcq_pkg::S_IDLE), query_bad};
          end
          swcq_pkg::A_CONFIG: rdat_d = {31'h0, prot_q};
          swcq_pkg::A_QUERY_LO: rdat_d = query_q[31:0];
          swcq_pkg::A_QUERY_HI: rdat_d = query_q[63:32];
          default: rdat_d = 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      stage_q <= '{default: '0};
      sq_q <= '{default: '0};
      tail_q <= '{default: '0};
      cq_head_q <= 2'h0;
      query_q <= 64'h0;
      prot_q <= 1'b0;
      ack_q <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end else begin
      stage_q <= stage_d;
      sq_q <= sq_d;
      tail_q <= tail_d;
      cq_head_q <= cq_head_d;
      query_q <= query_d;
      prot_q <= prot_d;
      ack_q <= ack_d;
      rdat_q <= rdat_d;
    end
  end

  // Engine side: fetch, check, execute, post.
  always_comb begin
    state_d = state_q;
    head_d = head_q;
    cq_d = cq_q;
    cq_tail_d = cq_tail_q;
    bad_d = bad_q;
    cmd_d = cmd_q;
    status_d = status_q;
    fair_d = fair_q;
    placed = 1'b0;
    case (state_q)
      swcq_pkg::S_IDLE: begin
        if (((cnt[0] != 2'h0) || (cnt[1] != 2'h0)) && !cq_full) begin
          state_d = swcq_pkg::S_ARB;
        end
      end
      swcq_pkg::S_ARB: begin
        cmd_d = decode(pick, sel, prot_q);
        head_d[sel] = 2'(head_q[sel] + 2'h1);
        fair_d = sel ? 2'h0 : 2'(fair_q + 2'h1);
        state_d = swcq_pkg::S_POST;
        status_d = swcq_pkg::ST_OK;
        if (pick[swcq_pkg::W_CMD0][7:0] == swcq_pkg::OP_WRITE) begin
          if ((pick[swcq_pkg::W_CDW12][25:16] != 10'h0) ||
              (pick[swcq_pkg::W_CDW13][31:8] != 24'h0)) begin
            status_d = swcq_pkg::ST_CONFLICT;
          end else if ((pick[swcq_pkg::W_CDW12][29:26] != 4'h0) && !prot_q) begin
            status_d = swcq_pkg::ST_BAD_PROT;
          end else begin
            state_d = swcq_pkg::S_EXEC;
          end
        end else if (pick[swcq_pkg::W_CMD0][7:0] == swcq_pkg::OP_UNCORR) begin
          status_d = swcq_pkg::ST_BAD_TABLE_FULL;
          for (int b = 0; b < swcq_pkg::BAD_N; b++) begin
            if (!bad_q[b].valid && !placed) begin
              placed = 1'b1;
              status_d = swcq_pkg::ST_OK;
              bad_d[b].valid = 1'b1;
              bad_d[b].first = {pick[swcq_pkg::W_CDW10 + 4'h1], pick[swcq_pkg::W_CDW10]};
              bad_d[b].last = bad_d[b].first + {48'h0, pick[swcq_pkg::W_CDW12][15:0]};
            end
          end
        end else begin
          status_d = swcq_pkg::ST_BAD_OPCODE;
        end
      end
      swcq_pkg::S_EXEC: begin
        // A forced write waits for the media commit as well as the back end's done.
        if (i_exec_done && (!cmd_q.force_media_flag || i_exec_committed)) begin
          status_d = i_exec_status;
          state_d = swcq_pkg::S_POST;
          if (i_exec_status == swcq_pkg::ST_OK) begin
            for (int b = 0; b < swcq_pkg::BAD_N; b++) begin
              if (overlaps(cmd_q.start_block_address, last_blk, bad_q[b].first,
                           bad_q[b].last)) begin
                bad_d[b].valid = 1'b0;
              end
            end
          end
        end
      end
      swcq_pkg::S_POST: begin
        cq_d[cq_tail_q].sq_id = cmd_q.sq_id;
        cq_d[cq_tail_q].cid = cmd_q.cid;
        cq_d[cq_tail_q].status = status_q;
        cq_d[cq_tail_q].sq_head = head_q[cmd_q.sq_id];
        cq_tail_d = 2'(cq_tail_q + 2'h1);
        state_d = swcq_pkg::S_IDLE;
      end
      default: state_d = swcq_pkg::S_IDLE;
    endcase
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_q <= swcq_pkg::S_IDLE;
      head_q <= '{default: '0};
      cq_q <= '{default: '0};
      cq_tail_q <= 2'h0;
      bad_q <= '{default: '0};
      cmd_q <= '0;
      status_q <= 8'h00;
      fair_q <= 2'h0;
    end else begin
      state_q <= state_d;
      head_q <= head_d;
      cq_q <= cq_d;
      cq_tail_q <= cq_tail_d;
      bad_q <= bad_d;
      cmd_q <= cmd_d;
      status_q <= status_d;
      fair_q <= fair_d;
    end
  end

  assign o_wb_ack = ack_q;
  assign o_wb_dat = rdat_q;
  assign o_exec_valid = (state_q == swcq_pkg::S_EXEC);
  assign o_exec = cmd_q;
  assign o_cq_pending = (cq_tail_q != cq_head_q);

  AST_WB_ACK_ONE: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (i_wb_cyc && i_wb_stb && !o_wb_ack) |=> o_wb_ack ##1 !o_wb_ack)
    else $error("Wishbone ack not a single cycle after request.");
  AST_CQ_NOT_OVERFULL: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (state_q == swcq_pkg::S_POST) |-> (ring_dist(cq_tail_q, cq_head_q) != 2'h3))
    else $error("Completion posted into a full ring.");
  AST_EXEC_POSTS: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (o_exec_valid && i_exec_done && !o_exec.force_media_flag)
      |=> (state_q == swcq_pkg::S_POST) ##1 (cq_tail_q == $past(cq_tail_q) + 2'h1))
    else $error("Finished command did not post a completion.");
  AST_FORCE_HOLDS: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (o_exec_valid && o_exec.force_media_flag && !i_exec_committed) |=> o_exec_valid)
    else $error("Forced write completed before media commit.");
  AST_TAGS_GATED: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (o_exec_valid && !prot_q) |-> (o_exec.initial_reference_tag == 32'h0 &&
                                  o_exec.application_tag_mask == 16'h0))
    else $error("Protection tags passed on an unprotected namespace.");
  AST_COUNT_PLUS_ONE: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (state_q == swcq_pkg::S_ARB) |=>
      (cmd_q.block_count == {1'b0, $past(pick[swcq_pkg::W_CDW12][15:0])} + 17'h1))
    else $error("Block count is not field plus one.");
  AST_CQE_IDS: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (state_q == swcq_pkg::S_POST) |=> (cq_q[$past(cq_tail_q)].cid == $past(cmd_q.cid) &&
                                       cq_q[$past(cq_tail_q)].sq_id == $past(cmd_q.sq_id)))
    else $error("Completion entry lost its identifiers.");
  AST_BAD_PROT_STATUS: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (state_q == swcq_pkg::S_ARB && pick[swcq_pkg::W_CMD0][7:0] == swcq_pkg::OP_WRITE &&
     pick[swcq_pkg::W_CDW12][25:16] == 10'h0 && pick[swcq_pkg::W_CDW13][31:8] == 24'h0 &&
     pick[swcq_pkg::W_CDW12][29:26] != 4'h0 && !prot_q)
      |=> (status_q == swcq_pkg::ST_BAD_PROT) ##1 (cq_tail_q == $past(cq_tail_q) + 2'h1))
    else $error("Invalid protection not reported as 81h.");
endmodule // swcq_engine

// [verilog/swcq_pkg.sv]
// Shared constants, types and register map of the write command queue engine.
package swcq_pkg;
  localparam int NWORDS = 13;
  localparam logic [3:0] W_CMD0 = 4'h0;
  localparam logic [3:0] W_MD_LO = 4'h1;
  localparam logic [3:0] W_P1_LO = 4'h3;
  localparam logic [3:0] W_P2_LO = 4'h5;
  localparam logic [3:0] W_CDW10 = 4'h7;
  localparam logic [3:0] W_CDW12 = 4'h9;
  localparam logic [3:0] W_CDW13 = 4'hA;
  localparam logic [3:0] W_CDW14 = 4'hB;
  localparam logic [3:0] W_CDW15 = 4'hC;
  // Byte offsets; 0x00 to 0x30 are the staged command words in order.
  localparam logic [7:0] A_STAGE_LAST = 8'h30;
  localparam logic [7:0] A_SLOT_WRITE = 8'h34;
  localparam logic [7:0] A_SQ0_TAIL = 8'h38;
  localparam logic [7:0] A_SQ1_TAIL = 8'h3C;
  localparam logic [7:0] A_CQ_HEAD = 8'h40;
  localparam logic [7:0] A_CQ_ENTRY = 8'h44;
  localparam logic [7:0] A_STATUS = 8'h48;
  localparam logic [7:0] A_CONFIG = 8'h4C;
  localparam logic [7:0] A_QUERY_LO = 8'h50;
  localparam logic [7:0] A_QUERY_HI = 8'h54;
  localparam logic [7:0] OP_WRITE = 8'h01;
  localparam logic [7:0] OP_UNCORR = 8'h04;
  localparam logic [7:0] ST_OK = 8'h00;
  localparam logic [7:0] ST_BAD_OPCODE = 8'h01;
  localparam logic [7:0] ST_BAD_TABLE_FULL = 8'h06;
  localparam logic [7:0] ST_CONFLICT = 8'h80;
  localparam logic [7:0] ST_BAD_PROT = 8'h81;
  localparam logic [1:0] FAIR_BURST = 2'h3;
  localparam int BAD_N = 4;
  localparam logic [29:0] BLOCK_BYTES = 30'h0000_0200;
  localparam logic [29:0] PAGE_BYTES = 30'h0000_1000;
  typedef enum logic [1:0] {PTR2_IGNORED = 2'h0, PTR2_DATA = 2'h1, PTR2_LIST = 2'h2} swcq_ptr2_e;
  typedef enum logic [1:0] {S_IDLE = 2'h0, S_ARB = 2'h1, S_EXEC = 2'h3, S_POST = 2'h2} swcq_state_e;
  typedef struct packed {
    logic sq_id;
    logic high_priority;
    logic [15:0] cid;
    logic [63:0] metadata_pointer;
    logic [63:0] first_data_pointer;
    logic [63:0] second_data_pointer;
    swcq_ptr2_e ptr2_use;
    logic [63:0] start_block_address;
    logic [16:0] block_count;
    logic limited_retry_flag;
    logic force_media_flag;
    logic [3:0] protection_action_field;
    logic [7:0] dataset_hint_field;
    logic incompressible;
    logic [31:0] initial_reference_tag;
    logic [15:0] application_tag_mask;
    logic [15:0] application_tag_value;
  } swcq_exec_s;
  typedef struct packed {
    logic sq_id;
    logic [15:0] cid;
    logic [7:0] status;
    logic [1:0] sq_head;
  } swcq_cqe_s;
  typedef struct packed {
    logic valid;
    logic [63:0] first;
    logic [63:0] last;
  } swcq_bad_s;
endpackage

// [test/swcq_media_model.sv]
// Behavioural media back end that answers the engine's execution port.
`timescale 1ns/1ps
module swcq_media_model (
  // Clock and reset.
  input wire logic i_mclk,
  input wire logic i_rst_b,
  // Request from the engine, pacing from the bench.
  input wire logic i_exec_valid,
  input wire logic [7:0] i_delay,
  input wire logic [7:0] i_lag,
  input wire logic [7:0] i_status,
  // Answer towards the engine.
  output logic o_done,
  output logic o_committed,
  output logic [7:0] o_status
);
  logic [7:0] cnt_q;
  logic [7:0] cnt_d;
  always_comb begin
    cnt_d = cnt_q;
    if (!i_exec_valid) begin
      cnt_d = 8'h00;
    end else if (cnt_q != 8'hFF) begin
      cnt_d = cnt_q + 8'h01;
    end
  end
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cnt_q <= 8'h00;
    end else begin
      cnt_q <= cnt_d;
    end
  end
  // Commit trails the transfer, so a forced commit visibly holds completion back.
  assign o_done = i_exec_valid && (cnt_q >= i_delay);
  assign o_committed = i_exec_valid && ({1'b0, cnt_q} >= ({1'b0, i_delay} + {1'b0, i_lag}));
  // Outside a transfer the status lines show the inverse, never the last answer.
  assign o_status = o_done ? i_status : ~i_status;
endmodule // swcq_media_model

// [test/storage_write_cmd_queue_tb.sv]
// Self-checking bench of the write command queue engine with a media model.
`timescale 1ns/1ps
module storage_write_cmd_queue_tb;
  logic i_mclk, i_rst_b, cyc, stb, we, ack, valid, done, cmt, pend;
  logic [7:0] adr, est, dly, lag, mst;
  logic [31:0] wdat, dat, rdat;
  swcq_pkg::swcq_exec_s exe, cap;
  logic [31:0] cw [13];
  logic [1:0] tl [2];
  logic [1:0] chd;
  int vcnt, miscompares, total_checks;
  swcq_engine dut_u (
    .i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
    .i_wb_adr(adr), .i_wb_dat(wdat), .i_wb_sel(4'hF), .o_wb_dat(dat), .o_wb_ack(ack),
    .o_exec_valid(valid), .o_exec(exe), .i_exec_done(done), .i_exec_committed(cmt),
    .i_exec_status(est), .o_cq_pending(pend));
  swcq_media_model media_u (
    .i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_exec_valid(valid), .i_delay(dly), .i_lag(lag),
    .i_status(mst), .o_done(done), .o_committed(cmt), .o_status(est));
  always @(posedge i_mclk) begin
    if (valid === 1'b1) begin
      if (vcnt == 0) cap <= exe;
      vcnt <= vcnt + 1;
    end
  end
  task automatic check(input logic [63:0] s, input logic [63:0] e);
    total_checks++;
    if (s !== e) begin
      miscompares++;
      $display("[ERR] t=%0t seen=%0h exp=%0h", $time, s, e);
    end
  endtask
  // Requests stay up until the edge that samples ack; the next call leaves an idle cycle.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge i_mclk);
      n++;
    end while (ack !== 1'b1 && n < 100);
    rdat = dat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 100) check(ack, 1'b1);
  endtask
  task automatic mk(input logic [7:0] op, input logic [15:0] id, input logic [31:0] lba,
                    input logic [31:0] w12, input logic [31:0] w13);
    cw = '{{id, 8'h00, op}, 32'h1000_0004, 32'h1, 32'h0002_0000, 32'h0, 32'h0003_0000,
           32'h0, lba, 32'h7, w12, w13, 32'hA5A5_5A5A, 32'h1234_5678};
  endtask
  task automatic submit(input logic q, input logic ring);
    for (int i = 0; i < 13; i++) wb(1'b1, 8'(4 * i), cw[i]);
    wb(1'b1, swcq_pkg::A_SLOT_WRITE, {23'h0, q, 6'h0, tl[q]});
    tl[q] = tl[q] + 2'h1;
    if (ring) wb(1'b1, q ? swcq_pkg::A_SQ1_TAIL : swcq_pkg::A_SQ0_TAIL, {30'h0, tl[q]});
  endtask
  task automatic cqe(input logic [15:0] id, input logic [7:0] st, input logic q,
                     input logic [1:0] hd);
    int n;
    n = 0;
    while (pend !== 1'b1 && n < 300) begin
      @(posedge i_mclk);
      n++;
    end
    check(pend, 1'b1);
    wb(1'b0, swcq_pkg::A_CQ_ENTRY, 32'h0);
    check(rdat, {id, st, 2'h0, hd, 3'h0, q});
    chd = chd + 2'h1;
    wb(1'b1, swcq_pkg::A_CQ_HEAD, {30'h0, chd});
  endtask
  task automatic query(input logic [31:0] lo, input logic e);
    wb(1'b1, swcq_pkg::A_QUERY_LO, lo);
    wb(1'b1, swcq_pkg::A_QUERY_HI, 32'h7);
    wb(1'b0, swcq_pkg::A_STATUS, 32'h0);
    check(rdat[0], e);
  endtask
  task automatic t_reset();
    check({pend, valid}, 2'h0);
    wb(1'b0, swcq_pkg::A_STATUS, 32'h0);
    check(rdat, 32'h0);
    wb(1'b1, 8'h80, 32'hFFFF_FFFF);
    wb(1'b0, 8'h80, 32'h0);
    check(rdat, 32'h0);
    $display("reset test done");
  endtask
  task automatic dec(input logic p, input logic [31:0] w12, input logic [7:0] w13,
                     input swcq_pkg::swcq_ptr2_e pt);
    wb(1'b1, swcq_pkg::A_CONFIG, {31'h0, p});
    mk(swcq_pkg::OP_WRITE, 16'h0050, 32'h89AB_CDEF, w12, {24'h0, w13});
    vcnt = 0;
    submit(1'b0, 1'b1);
    cqe(16'h0050, 8'h00, 1'b0, tl[0]);
    check(vcnt, int'(dly) + 1 + (w12[30] ? int'(lag) : 0));
    check(cap.start_block_address, 64'h7_89AB_CDEF);
    check(cap.metadata_pointer, 64'h1_1000_0004);
    check(cap.second_data_pointer, 64'h3_0000);
    check(cap.first_data_pointer, 64'h2_0000);
    check({cap.sq_id, cap.high_priority, cap.cid}, {2'b01, 16'h0050});
    check(cap.ptr2_use, pt);
    check(cap.block_count, {1'b0, w12[15:0]} + 17'h1);
    check({cap.limited_retry_flag, cap.force_media_flag}, w12[31:30]);
    check(cap.protection_action_field, w12[29:26]);
    check({cap.dataset_hint_field, cap.incompressible}, {w13, w13[7]});
    check(cap.initial_reference_tag, p ? 32'hA5A5_5A5A : 32'h0);
    check({cap.application_tag_mask, cap.application_tag_value}, p ? 32'h1234_5678 : 0);
    $display("decode test done");
  endtask
  task automatic t_err();
    logic [31:0] w12 [4] = '{32'h0001_0000, 32'h0, 32'h0400_0000, 32'h0};
    logic [31:0] w13 [4] = '{32'h0, 32'h0000_0100, 32'h0, 32'h0};
    logic [7:0] st [4] = '{8'h80, 8'h80, 8'h81, swcq_pkg::ST_BAD_OPCODE};
    for (int i = 0; i < 4; i++) begin
      vcnt = 0;
      mk(i == 3 ? 8'h02 : swcq_pkg::OP_WRITE, 16'(i), 32'h0, w12[i], w13[i]);
      submit(1'b0, 1'b1);
      cqe(16'(i), st[i], 1'b0, tl[0]);
      check(vcnt, 0);
    end
    $display("error status test done");
  endtask
  task automatic t_unc();
    vcnt = 0;
    mk(swcq_pkg::OP_UNCORR, 16'h0031, 32'h0000_0100, 32'h0000_0003, 32'h0);
    submit(1'b0, 1'b1);
    cqe(16'h0031, 8'h00, 1'b0, tl[0]);
    check(vcnt, 0);
    query(32'h0000_00FF, 1'b0);
    query(32'h0000_0103, 1'b1);
    query(32'h0000_0104, 1'b0);
    mk(swcq_pkg::OP_WRITE, 16'h0032, 32'h0000_0102, 32'h0, 32'h0);
    submit(1'b0, 1'b1);
    cqe(16'h0032, 8'h00, 1'b0, tl[0]);
    query(32'h0000_0100, 1'b0);
    $display("uncorrectable test done");
  endtask
  // A long transfer on ring one lets ring zero arrive meanwhile and overtake.
  task automatic t_prio();
    dly <= 8'd20;
    mk(swcq_pkg::OP_WRITE, 16'h0011, 32'h0, 32'h0, 32'h0);
    submit(1'b1, 1'b0);
    mk(swcq_pkg::OP_WRITE, 16'h0012, 32'h0, 32'h0, 32'h0);
    submit(1'b1, 1'b0);
    mk(swcq_pkg::OP_WRITE, 16'h0021, 32'h0, 32'h0, 32'h0);
    submit(1'b0, 1'b0);
    wb(1'b1, swcq_pkg::A_SQ1_TAIL, {30'h0, tl[1]});
    wb(1'b1, swcq_pkg::A_SQ0_TAIL, {30'h0, tl[0]});
    cqe(16'h0011, 8'h00, 1'b1, tl[1] - 2'h1);
    cqe(16'h0021, 8'h00, 1'b0, tl[0]);
    cqe(16'h0012, 8'h00, 1'b1, tl[1]);
    @(posedge i_mclk);
    check(pend, 1'b0);
    $display("priority test done");
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    i_mclk = 1'b0;
    forever #10 i_mclk = ~i_mclk;
  end
  initial begin
    {i_rst_b, cyc, stb, we, adr, wdat, chd} = '0;
    {dly, lag, mst} = {8'd2, 8'd3, 8'h00};
    tl = '{2'h0, 2'h0};
    {vcnt, miscompares, total_checks} = '0;
    repeat (10) @(posedge i_mclk);
    i_rst_b <= 1'b1;
    t_reset();
    dec(1'b1, 32'hA400_000F, 8'h87, swcq_pkg::PTR2_DATA);
    dec(1'b0, 32'h4000_0007, 8'h05, swcq_pkg::PTR2_IGNORED);
    dec(1'b0, 32'h0000_001F, 8'h00, swcq_pkg::PTR2_LIST);
    t_err();
    t_unc();
    t_prio();
    final_report();
  end
  initial begin
    #600000;
    miscompares++;
    final_report();
  end
endmodule // storage_write_cmd_queue_tb
